// File: src/fspc_pkg.sv
// Package of constants and types for the flash self-programming control block
//
// Contract
// [RULE1] Stall processor while operation is in progress
// [RULE2] Start bit begins operation, hardware clears it
// [RULE3] Software writes key 0x55 then 0xAA consecutively
// [RULE4] Unlock key register is write-only
// [RULE5] Start bit set-only by software, resets zero
// [RULE6] Erase select bit chooses erase or program
// [RULE7] Row write lasts 11064 oscillator cycles
// [RULE8] Page erase uses op_select 0010 with erase
// [RULE9] Row program uses op_select 0001 without erase
// [RULE10] Start without unlock sets sequence error flag
package fspc_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [3:0] FSPC_ADDR_CONTROL = 4'h0;
   localparam logic [3:0] FSPC_ADDR_KEY = 4'h1;
   localparam logic [3:0] FSPC_ADDR_IRQ_STATUS = 4'h2;
   localparam logic [3:0] FSPC_ADDR_IRQ_ENABLE = 4'h3;
   localparam logic [3:0] FSPC_ADDR_IRQ_CLEAR = 4'h4;
   // ==========================================================
   // Control register fields
   localparam int FSPC_BIT_START = 15;
   localparam int FSPC_BIT_PROG_ENABLE = 14;
   localparam int FSPC_BIT_SEQ_ERROR = 13;
   localparam int FSPC_BIT_ERASE = 6;
   localparam logic [15:0] FSPC_CONTROL_RESET = 16'h0000;
   localparam logic [15:0] FSPC_CONTROL_WMASK = 16'h4047;
   // ==========================================================
   // Keys and operation codes
   localparam logic [7:0] FSPC_KEY_FIRST = 8'h55;
   localparam logic [7:0] FSPC_KEY_SECOND = 8'hAA;
   localparam logic [3:0] FSPC_OP_PAGE_ERASE = 4'h2;
   localparam logic [3:0] FSPC_OP_ROW_PROGRAM = 4'h1;
   localparam logic [3:0] FSPC_OP_WORD_PROGRAM = 4'h3;
   // ==========================================================
   // Timing: oscillator cycles per operation, oscillator rate in kHz
   localparam int FSPC_ROW_WRITE_OSC_CYCLES = 11064;
   localparam int FSPC_OSC_KHZ = 7370;
   localparam int FSPC_CORE_KHZ = 100000;
   localparam int FSPC_ROW_WRITE_CORE_CYCLES =
      (FSPC_ROW_WRITE_OSC_CYCLES * (FSPC_CORE_KHZ / 1000) * 1000 + FSPC_OSC_KHZ - 1)
      / FSPC_OSC_KHZ;
   // ==========================================================
   // Interrupt status bits
   localparam int FSPC_IRQ_DONE = 0;
   localparam int FSPC_IRQ_SEQ_ERR = 1;
   localparam logic [1:0] FSPC_IRQ_RESET = 2'h0;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      FSPC_KEY_IDLE = 2'b00,
      FSPC_KEY_GOT_FIRST = 2'b01,
      FSPC_KEY_UNLOCKED = 2'b10
   } fspc_key_state_t;
endpackage

// File: src/fspc_timer_if.sv
// Interface between the sequencer and its operation timer
`timescale 1ns/1ps
`default_nettype none
interface fspc_timer_if;
   logic start;
   logic busy;
   logic done;
   modport ctrl (output start, input busy, input done);
   modport timer (input start, output busy, output done);
endinterface
`default_nettype wire

// File: src/fspc_op_timer.sv
// Self-timed operation counter on core_clk, stepped by an internal fractional oscillator-rate tick
`timescale 1ns/1ps
`default_nettype none
module fspc_op_timer
   import fspc_pkg::*;
#(
   parameter int OSC_CYCLES = FSPC_ROW_WRITE_OSC_CYCLES,
   parameter int OSC_KHZ = FSPC_OSC_KHZ,
   parameter int CORE_KHZ = FSPC_CORE_KHZ
) (
   input wire logic core_clk,
   input wire logic rst,
   fspc_timer_if.timer tif
);
   // ==========================================================
   // State
   typedef struct packed {
      logic [31:0] phase;
      logic [15:0] remain;
      logic busy;
      logic done;
   } fspc_timer_state_t;
   fspc_timer_state_t state_ff;
   fspc_timer_state_t nxt_state;

   // ==========================================================
   // Fractional divider: one tick per oscillator cycle
   always_comb begin
      nxt_state = state_ff;
      nxt_state.done = 1'b0;
      if (tif.start && !state_ff.busy) begin
         nxt_state.busy = 1'b1;
         nxt_state.remain = 16'(OSC_CYCLES); // see [RULE7]
         nxt_state.phase = 32'h0000_0000;
      end else if (state_ff.busy) begin
         if (state_ff.phase + 32'(OSC_KHZ) >= 32'(CORE_KHZ)) begin
            nxt_state.phase = state_ff.phase + 32'(OSC_KHZ) - 32'(CORE_KHZ);
            if (state_ff.remain == 16'h0001) begin
               nxt_state.busy = 1'b0; // see [RULE7]
               nxt_state.done = 1'b1;
               nxt_state.remain = 16'h0000;
            end else begin
               nxt_state.remain = state_ff.remain - 16'h0001;
            end
         end else begin
            nxt_state.phase = state_ff.phase + 32'(OSC_KHZ);
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign tif.busy = state_ff.busy;
   assign tif.done = state_ff.done;
endmodule
`default_nettype wire

// File: src/fspc_top.sv
// Flash self-programming sequencer with control, key and interrupt registers
`timescale 1ns/1ps
`default_nettype none
module fspc_top
   import fspc_pkg::*;
#(
   parameter int OSC_CYCLES = FSPC_ROW_WRITE_OSC_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   output logic cpu_stall,
   output logic flash_erase,
   output logic flash_program,
   output logic [3:0] flash_op,
   output logic irq
);
   // ==========================================================
   // State
   typedef struct packed {
      logic start;
      logic prog_enable;
      logic seq_error;
      logic erase;
      logic [3:0] op_select;
      fspc_key_state_t key;
      logic [1:0] irq_status;
      logic [1:0] irq_enable;
      logic [15:0] rdata;
      logic run;
      logic run_erase;
      logic [3:0] run_op;
   } fspc_state_t;
   fspc_state_t state_ff;
   fspc_state_t nxt_state;

   fspc_timer_if tif ();

   fspc_op_timer #(.OSC_CYCLES(OSC_CYCLES)) u_timer (
      .core_clk(core_clk),
      .rst(rst),
      .tif(tif)
   );

   function automatic logic [15:0] control_word(input fspc_state_t s);
      logic [15:0] w;
      w = 16'h0000;
      w[FSPC_BIT_START] = s.start;
      w[FSPC_BIT_PROG_ENABLE] = s.prog_enable;
      w[FSPC_BIT_SEQ_ERROR] = s.seq_error;
      w[FSPC_BIT_ERASE] = s.erase;
      w[3:0] = s.op_select;
      return w;
   endfunction

   logic ctl_wr;
   logic start_req;
   logic [1:0] irq_set;

   // ==========================================================
   // Next-state logic
   always_comb begin
      nxt_state = state_ff;
      ctl_wr = reg_wr && (reg_addr == FSPC_ADDR_CONTROL);
      start_req = ctl_wr && reg_wdata[FSPC_BIT_START] && !state_ff.start;
      irq_set = 2'b00;
      tif.start = 1'b0;
      // Any register write other than the second key breaks the unlock
      if (reg_wr) begin
         nxt_state.key = FSPC_KEY_IDLE; // see [RULE3]
      end
      if (reg_wr && reg_addr == FSPC_ADDR_KEY) begin
         if (reg_wdata[7:0] == FSPC_KEY_FIRST) begin
            nxt_state.key = FSPC_KEY_GOT_FIRST; // see [RULE3]
         end else if (reg_wdata[7:0] == FSPC_KEY_SECOND && state_ff.key == FSPC_KEY_GOT_FIRST) begin
            nxt_state.key = FSPC_KEY_UNLOCKED; // see [RULE3]
         end
      end
      if (ctl_wr && !state_ff.start) begin
         nxt_state.prog_enable = reg_wdata[FSPC_BIT_PROG_ENABLE];
         nxt_state.erase = reg_wdata[FSPC_BIT_ERASE]; // see [RULE6]
         nxt_state.op_select = reg_wdata[3:0];
         if (!reg_wdata[FSPC_BIT_SEQ_ERROR]) begin
            nxt_state.seq_error = 1'b0;
         end
      end
      if (start_req) begin
         if (state_ff.key == FSPC_KEY_UNLOCKED && reg_wdata[FSPC_BIT_PROG_ENABLE]) begin
            nxt_state.start = 1'b1; // see [RULE5]
            nxt_state.seq_error = 1'b0; // see [RULE10]
            nxt_state.run = 1'b1;
            nxt_state.run_erase = reg_wdata[FSPC_BIT_ERASE]; // see [RULE6]
            nxt_state.run_op = reg_wdata[3:0];
            tif.start = 1'b1; // see [RULE2]
         end else begin
            nxt_state.seq_error = 1'b1; // see [RULE10]
            irq_set[FSPC_IRQ_SEQ_ERR] = 1'b1;
         end
      end
      if (tif.done) begin
         nxt_state.start = 1'b0; // see [RULE2]
         nxt_state.run = 1'b0;
         irq_set[FSPC_IRQ_DONE] = 1'b1;
      end
      // Interrupt registers: set wins over clear
      if (reg_wr && reg_addr == FSPC_ADDR_IRQ_ENABLE) begin
         nxt_state.irq_enable = reg_wdata[1:0];
      end
      if (reg_wr && reg_addr == FSPC_ADDR_IRQ_CLEAR) begin
         nxt_state.irq_status = state_ff.irq_status & ~reg_wdata[1:0];
      end
      nxt_state.irq_status = nxt_state.irq_status | irq_set;
      // Read data; key reads as zero
      nxt_state.rdata = 16'h0000;
      if (reg_rd) begin
         if (reg_addr == FSPC_ADDR_CONTROL) begin
            nxt_state.rdata = control_word(state_ff);
         end else if (reg_addr == FSPC_ADDR_KEY) begin
            nxt_state.rdata = 16'h0000; // see [RULE4]
         end else if (reg_addr == FSPC_ADDR_IRQ_STATUS) begin
            nxt_state.rdata = {14'h0000, state_ff.irq_status};
         end else if (reg_addr == FSPC_ADDR_IRQ_ENABLE) begin
            nxt_state.rdata = {14'h0000, state_ff.irq_enable};
         end else begin
            nxt_state.rdata = 16'h0000;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_ff <= '{start: 1'b0, prog_enable: 1'b0, seq_error: 1'b0, erase: 1'b0,
                      op_select: 4'h0, key: FSPC_KEY_IDLE, irq_status: FSPC_IRQ_RESET,
                      irq_enable: 2'h0, rdata: 16'h0000, run: 1'b0, run_erase: 1'b0,
                      run_op: 4'h0};
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ==========================================================
   // Outputs
   assign reg_rdata = state_ff.rdata;
   assign cpu_stall = state_ff.run; // see [RULE1]
   assign flash_erase = state_ff.run && state_ff.run_erase; // see [RULE8]
   assign flash_program = state_ff.run && !state_ff.run_erase; // see [RULE9]
   assign flash_op = state_ff.run_op;
   assign irq = |(state_ff.irq_status & state_ff.irq_enable);
endmodule
`default_nettype wire

// File: verification/fspc_assertions.sv
// Port-level assertion checker for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module fspc_assertions
   import fspc_pkg::*;
#(
   parameter int OSC_CYCLES = FSPC_ROW_WRITE_OSC_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic cpu_stall,
   input wire logic flash_erase,
   input wire logic flash_program,
   input wire logic [3:0] flash_op,
   input wire logic irq
);
   localparam int LIM = (OSC_CYCLES * FSPC_CORE_KHZ + FSPC_OSC_KHZ - 1) / FSPC_OSC_KHZ;
   int cnt_ff;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= 0;
      end else begin
         cnt_ff <= cpu_stall ? cnt_ff + 1 : 0;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence op_run;
      cpu_stall && (flash_erase ^ flash_program);
   endsequence
   sequence mask_off;
      reg_wr && reg_addr == FSPC_ADDR_IRQ_ENABLE && reg_wdata[1:0] == 2'h0;
   endsequence
   a_stall_cause: assert property ($rose(cpu_stall) |-> $past(reg_wr) &&
      $past(reg_wdata[15]) && $past(reg_addr) == FSPC_ADDR_CONTROL) else $error("stall without start");
   a_erase_sel: assert property ($rose(cpu_stall) |->
      flash_erase == $past(reg_wdata[6])) else $error("wrong operation type");
   a_op_latch: assert property ($rose(cpu_stall) |->
      flash_op == $past(reg_wdata[3:0])) else $error("wrong operation code");
   a_op_held: assert property ($rose(cpu_stall) |-> op_run [*8])
      else $error("operation dropped");
   a_type_idle: assert property (!cpu_stall |-> !flash_erase && !flash_program)
      else $error("flash active while idle");
   a_start_bit: assert property ($past(reg_rd) && $past(reg_addr) == FSPC_ADDR_CONTROL |->
      reg_rdata[15] == $past(cpu_stall)) else $error("start bit mismatch");
   a_key_hidden: assert property ($past(reg_rd) && $past(reg_addr) == FSPC_ADDR_KEY |->
      reg_rdata == 16'h0000) else $error("key readable");
   a_stall_max: assert property (cnt_ff <= LIM + 3)
      else $error("operation too long");
   a_stall_min: assert property ($fell(cpu_stall) |-> $past(cnt_ff) >= LIM - 3)
      else $error("operation too short");
   a_irq_mask: assert property (mask_off |-> ##1 !irq) else $error("masked irq high");
endmodule
bind fspc_top fspc_assertions #(.OSC_CYCLES(OSC_CYCLES)) chk_inst (
   .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_stall(cpu_stall),
   .flash_erase(flash_erase), .flash_program(flash_program), .flash_op(flash_op), .irq(irq));
`default_nettype wire

// File: verification/fspc_sw_model.sv
// Processor software model driving the register port
`timescale 1ns/1ps
`default_nettype none
module fspc_sw_model
   import fspc_pkg::*;
(
   input wire logic core_clk,
   input wire logic [15:0] reg_rdata,
   output logic [3:0] reg_addr,
   output logic [15:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd
);
   initial begin
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic start(input logic [15:0] setup);
      wr(FSPC_ADDR_CONTROL, setup);
      wr(FSPC_ADDR_KEY, {8'h00, FSPC_KEY_FIRST});
      wr(FSPC_ADDR_KEY, {8'h00, FSPC_KEY_SECOND});
      wr(FSPC_ADDR_CONTROL, setup | 16'h8000);
   endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
// Self-checking testbench for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
   import fspc_pkg::*;
   localparam int OSC = 4;
   localparam int EXP = (OSC * FSPC_CORE_KHZ + FSPC_OSC_KHZ - 1) / FSPC_OSC_KHZ;
   logic core_clk, rst, reg_wr, reg_rd, cpu_stall, flash_erase, flash_program, irq;
   logic [3:0] reg_addr, flash_op;
   logic [15:0] reg_wdata, reg_rdata, v;
   int failures = 0;
   int checked = 0;
   int n;
   int cnt = 0;
   int cnt0;
   fspc_top #(.OSC_CYCLES(OSC)) fspc_top_inst (.core_clk(core_clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .cpu_stall(cpu_stall), .flash_erase(flash_erase),
      .flash_program(flash_program), .flash_op(flash_op), .irq(irq));
   fspc_sw_model sw (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (cpu_stall === 1'b1) cnt <= cnt + 1;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
      sw.rd(a, v);
      chk(v, exp);
   endtask
   task automatic ichk(input logic exp);
      repeat (2) @(posedge core_clk);
      #1;
      chk({15'h0000, irq}, {15'h0000, exp});
   endtask
   task automatic run_op(input logic [15:0] setup, input logic er, input logic [3:0] op);
      cnt0 = cnt;
      sw.start(setup);
      @(posedge core_clk);
      #1;
      chk({cpu_stall, flash_erase, flash_program, 9'h000, flash_op},
         {1'b1, er, ~er, 9'h000, op});
      rchk(FSPC_ADDR_CONTROL, setup | 16'h8000);
      sw.wr(FSPC_ADDR_CONTROL, setup);
      rchk(FSPC_ADDR_CONTROL, setup | 16'h8000);
      for (n = 0; n < 2000 && cpu_stall !== 1'b0; n++) @(posedge core_clk);
      if (n >= 2000) begin
         failures++;
         finish_test();
      end
      #1;
      chk({15'h0000, cnt - cnt0 >= EXP - 2 && cnt - cnt0 <= EXP + 3}, 16'h0001);
      rchk(FSPC_ADDR_CONTROL, setup);
   endtask
   initial begin
      rst = 1'b1;
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      rchk(FSPC_ADDR_CONTROL, FSPC_CONTROL_RESET);
      rchk(FSPC_ADDR_IRQ_STATUS, 16'h0000);
      sw.wr(FSPC_ADDR_IRQ_ENABLE, 16'h0003);
      sw.wr(FSPC_ADDR_CONTROL, 16'h4042);
      sw.wr(FSPC_ADDR_CONTROL, 16'hC042);
      rchk(FSPC_ADDR_CONTROL, 16'h6042);
      rchk(FSPC_ADDR_IRQ_STATUS, 16'h0002);
      ichk(1'b1);
      sw.wr(FSPC_ADDR_KEY, 16'h0055);
      rchk(FSPC_ADDR_KEY, 16'h0000);
      sw.wr(FSPC_ADDR_CONTROL, 16'h4042);
      sw.wr(FSPC_ADDR_KEY, 16'h00AA);
      sw.wr(FSPC_ADDR_CONTROL, 16'hC042);
      rchk(FSPC_ADDR_CONTROL, 16'h6042);
      sw.wr(FSPC_ADDR_IRQ_CLEAR, 16'h0003);
      ichk(1'b0);
      run_op(16'h4042, 1'b1, FSPC_OP_PAGE_ERASE);
      rchk(FSPC_ADDR_IRQ_STATUS, 16'h0001);
      ichk(1'b1);
      sw.wr(FSPC_ADDR_IRQ_ENABLE, 16'h0000);
      ichk(1'b0);
      sw.wr(FSPC_ADDR_IRQ_CLEAR, 16'h0003);
      run_op(16'h4001, 1'b0, FSPC_OP_ROW_PROGRAM);
      finish_test();
   end
endmodule
`default_nettype wire
